// [rtl/adc_serial_packet_encoder_regs.vh]
// constants for the per-channel serial packet encoder
`ifndef ADC_SERIAL_PACKET_ENCODER_REGS_VH
`define ADC_SERIAL_PACKET_ENCODER_REGS_VH

// user pattern byte registers, consecutive addresses
`define USER_PATTERN_BYTE_0 8'h19
`define USER_PATTERN_BYTE_1 8'h1A
`define USER_PATTERN_BYTE_2 8'h1B
`define USER_PATTERN_BYTE_3 8'h1C
`define USER_PATTERN_BYTE_4 8'h1D
`define USER_PATTERN_BYTE_5 8'h1E
`define USER_PATTERN_BYTE_6 8'h1F
`define USER_PATTERN_BYTE_7 8'h20
`define USER_PATTERN_RESET 8'h00

// test mode codes
`define TM_OFF 4'h0
`define TM_MIDSCALE 4'h1
`define TM_POS_FULL 4'h2
`define TM_NEG_FULL 4'h3
`define TM_CHECKER 4'h4
`define TM_PN_LONG 4'h5
`define TM_PN_SHORT 4'h6
`define TM_TOGGLE 4'h7
`define TM_USER 4'h8

// data format codes
`define FMT_OFFSET 2'h0
`define FMT_TWOS 2'h1
`define FMT_GRAY 2'h2

// scrambler select and coverage codes
`define SCR_NONE 2'h0
`define SCR_LONG 2'h1
`define SCR_SHORT 2'h2
`define SCR_INVERT 2'h3
`define COVER_64 2'h0
`define COVER_56 2'h1
`define COVER_48 2'h2

// packet geometry and timing
`define SAMPLE_W 12
`define PATTERN_W 14
`define HEADER_BITS 6'h08
`define DATA_END 6'h38
`define BIT_RATE_PER_SAMPLE 16
`define LAST_BIT_OF_SAMPLE 4'hF

// fixed pattern words, left aligned on 14 bits
`define PAT_MIDSCALE 14'h2000
`define PAT_ALL_ONES 14'h3FFF
`define PAT_CHECKER_A 14'h2AAA
`define PAT_CHECKER_B 14'h1555

// pseudorandom seeds
`define PN_SHORT_SEED 9'h0DF
`define PN_LONG_SEED 23'h29B80A

`endif

// [rtl/adc_serial_packet_encoder.v]
// serial packet encoder: patterns, format, ecc, scramblers, sample fifo
//
// How it works
// - mode 0 sends conversions; 1,2,3 repeat midscale, +full, -full scale.
// - mode 4 alternates 0xAAA/0x555; mode 7 alternates all ones/zeros.
// - checkerboard, toggle and user pattern skip format conversion; other patterns use it.
// - fixed patterns (not pseudorandom or user) can be built at word lengths 8 to 14.
// - user pattern comes from eight writable bytes at user_pattern_byte_0 to user_pattern_byte_7.
// - one control bit inverts the serial output, apart from bit order.
// - samples go MSB first by default, LSB first on request.
// - mode 6 sends the 2^9-1 pseudorandom sequence, period 511 bits.
// - short sequence seeded 0x0df; first samples 0xdf9, 0x353, 0x301.
// - mode 5 sends the inverted 2^23-1 pseudorandom sequence.
// - long sequence seeded 0x29b80a; first samples 0x591, 0xfd7, 0x0a3.
// - packet is 8 header bits, four 12-bit samples, 8 ecc bits.
// - one bit per bit time, sixteen per sample, one packet per four.
// - ecc is an eight-bit Hamming code; its top bit is always 0.
// - six low ecc bits are XORs of header and data bit subsets.
// - seventh ecc bit is parity over packet including six Hamming bits.
// - ecc bits sit together at packet end, after header and data.
// - scramblers: x^58+x^39+1, x^7+x^6+1, or static bit inverter.
// - polynomial scramblers cover 64, 56 or 48 bits; always step 64.
// - static inverter flips its positions in every packet, always.
// - format defaults to offset binary; twos complement or gray selectable.
`timescale 1ns/1ps
`include "adc_serial_packet_encoder_regs.vh"

////////////////////////////////////////////////////////////////////////////
module sample_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire ref_clk,
  input wire reset_n,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output reg inReady,
  output wire [WIDTH-1:0] outData,
  output reg outValid,
  input wire outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_q;
  reg [AW-1:0] rdPtr_q;
  reg [AW:0] count_q;
  reg [AW:0] count_d;
  wire push;
  wire pop;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr_q];

  always @*
  begin
    count_d = count_q;
    if (push && !pop)
      count_d = count_q + 1'b1;
    else if (pop && !push)
      count_d = count_q - 1'b1;
  end

  // full and empty are registered so the ready/valid outputs are flops
  always @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      inReady <= 1'b0;
      outValid <= 1'b0;
    end
    else
    begin
      if (push)
        wrPtr_q <= (wrPtr_q == DEPTH - 1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
      if (pop)
        rdPtr_q <= (rdPtr_q == DEPTH - 1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
      count_q <= count_d;
      inReady <= (count_d != DEPTH);
      outValid <= (count_d != {(AW+1){1'b0}});
    end
  end

  always @(posedge ref_clk)
  begin
    if (push)
      mem[wrPtr_q] <= inData;
  end
endmodule

////////////////////////////////////////////////////////////////////////////
module adc_serial_packet_encoder #(
  parameter [63:0] INV_MASK = 64'h00FF_0F0F_0F0F_0F00,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire ref_clk,
  input wire reset_n,
  input wire [11:0] sampleIn,
  input wire sampleValid,
  output wire sampleReady,
  input wire [7:0] headerByte,
  input wire [3:0] testMode,
  input wire [3:0] wordLen,
  input wire [1:0] dataFormat,
  input wire lsbFirst,
  input wire invertOut,
  input wire [1:0] scrambleSel,
  input wire [1:0] scrambleCover,
  input wire regWrEn,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  output reg [7:0] regRdData,
  output reg serialOut,
  output reg packetStart
);
  reg [5:0] bitCnt_q;
  reg [7:0] userPat_q [0:7];
  reg [11:0] slot_q [0:3];
  reg [11:0] lastRaw_q;
  reg [8:0] pnShort_q;
  reg [22:0] pnLong_q;
  reg [63:0] pkt_q;
  reg [57:0] scrLong_q;
  reg [6:0] scrShort_q;
  wire [11:0] fifoData;
  wire fifoValid;
  wire sampleTick;
  wire [1:0] slotIdx;
  wire [20:0] pnShortNext;
  wire [34:0] pnLongNext;
  wire [2:0] userIdx;
  wire userHit;
  wire [5:0] pos;
  reg [11:0] raw;
  reg [11:0] word;
  reg [55:0] body;
  reg inCover;
  reg txBit;
  reg longBit;
  reg shortBit;
  integer k;
  integer m;

  //////////////////////////////////////////////////////////////////////////
  // functions

  // step the short generator 12 times; returns {word, next state}
  function [20:0] pnShortWord;
    input [8:0] s;
    integer i;
    reg [8:0] st;
    reg [11:0] w;
    begin
      st = s;
      w = 12'h000;
      for (i = 0; i < 12; i = i + 1)
      begin
        w = {w[10:0], st[7]};
        st = {st[7:0], st[8] ^ st[4]};
      end
      pnShortWord = {w, st};
    end
  endfunction

  // long generator, output inverted against the standard stream
  function [34:0] pnLongWord;
    input [22:0] s;
    integer i;
    reg [22:0] st;
    reg [11:0] w;
    begin
      st = s;
      w = 12'h000;
      for (i = 0; i < 12; i = i + 1)
      begin
        w = {w[10:0], ~st[21]};
        st = {st[21:0], st[22] ^ st[17]};
      end
      pnLongWord = {w, st};
    end
  endfunction

  // fixed pattern at a word length, left aligned, then cut to 12 bits
  function [11:0] patWord;
    input [3:0] mode;
    input odd;
    input [3:0] len;
    reg [13:0] keep;
    reg [13:0] p;
    begin
      keep = ~(`PAT_ALL_ONES >> len);
      case (mode)
        `TM_MIDSCALE: p = `PAT_MIDSCALE;
        `TM_POS_FULL: p = `PAT_ALL_ONES;
        `TM_CHECKER: p = odd ? `PAT_CHECKER_B : `PAT_CHECKER_A;
        `TM_TOGGLE: p = odd ? 14'h0000 : `PAT_ALL_ONES;
        default: p = 14'h0000;
      endcase
      p = p & keep;
      patWord = p[13:2];
    end
  endfunction

  function [11:0] fmtWord;
    input [11:0] w;
    input [1:0] f;
    begin
      case (f)
        `FMT_TWOS: fmtWord = {~w[11], w[10:0]};
        `FMT_GRAY: fmtWord = w ^ {1'b0, w[11:1]};
        default: fmtWord = w;
      endcase
    end
  endfunction

  function [11:0] rev12;
    input [11:0] w;
    integer i;
    begin
      for (i = 0; i < 12; i = i + 1)
        rev12[i] = w[11 - i];
    end
  endfunction

  // hamming over 56 bits laid on codeword positions 63 down to 5,
  // skipping the power-of-two slots; returns {overall parity, p6..p1}
  function [6:0] eccBits;
    input [55:0] d;
    integer i;
    integer posn;
    reg [5:0] p;
    begin
      p = 6'h00;
      posn = 63;
      for (i = 55; i >= 0; i = i - 1)
      begin
        if ((posn & (posn - 1)) == 0)
          posn = posn - 1;
        if (d[i])
          p = p ^ posn[5:0];
        posn = posn - 1;
      end
      eccBits = {(^d) ^ (^p), p};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // sample buffer and bit timing

  sample_fifo #(
    .WIDTH(`SAMPLE_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .inData(sampleIn),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(sampleTick)
  );

  // sample clock is one tick per sixteen bit times
  assign sampleTick = (bitCnt_q[3:0] == `LAST_BIT_OF_SAMPLE);
  assign slotIdx = bitCnt_q[5:4];
  assign pnShortNext = pnShortWord(pnShort_q);
  assign pnLongNext = pnLongWord(pnLong_q);
  assign pos = bitCnt_q - 6'h01;

  always @(posedge ref_clk)
  begin
    if (!reset_n)
      bitCnt_q <= 6'h00;
    else
      bitCnt_q <= bitCnt_q + 6'h01;
  end

  //////////////////////////////////////////////////////////////////////////
  // user pattern registers

  assign userHit = (regAddr >= `USER_PATTERN_BYTE_0) &&
                   (regAddr <= `USER_PATTERN_BYTE_7);
  assign userIdx = regAddr[2:0] - 3'h1;

  always @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      for (k = 0; k < 8; k = k + 1)
        userPat_q[k] <= `USER_PATTERN_RESET;
      regRdData <= 8'h00;
    end
    else
    begin
      if (regWrEn && userHit)
        userPat_q[userIdx] <= regWrData;
      regRdData <= userHit ? userPat_q[userIdx] : 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sample source selection

  always @*
  begin
    raw = fifoValid ? fifoData : lastRaw_q;
    case (testMode)
      `TM_OFF: word = fmtWord(raw, dataFormat);
      `TM_MIDSCALE, `TM_POS_FULL, `TM_NEG_FULL:
        word = fmtWord(patWord(testMode, slotIdx[0], wordLen),
                       dataFormat);
      `TM_CHECKER, `TM_TOGGLE:
        word = patWord(testMode, slotIdx[0], wordLen);
      `TM_PN_LONG: word = fmtWord(pnLongNext[34:23], dataFormat);
      `TM_PN_SHORT: word = fmtWord(pnShortNext[20:9], dataFormat);
      `TM_USER: word = {userPat_q[{slotIdx, 1'b0}],
                        userPat_q[{slotIdx, 1'b1}][7:4]};
      default: word = 12'h000;
    endcase
    if (lsbFirst)
      word = rev12(word);
  end

  // an empty buffer repeats the last sample rather than stalling the link
  always @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      lastRaw_q <= 12'h000;
      pnShort_q <= `PN_SHORT_SEED;
      pnLong_q <= `PN_LONG_SEED;
      for (m = 0; m < 4; m = m + 1)
        slot_q[m] <= 12'h000;
    end
    else
    begin
      if (testMode != `TM_PN_SHORT)
        pnShort_q <= `PN_SHORT_SEED;
      else if (sampleTick)
        pnShort_q <= pnShortNext[8:0];
      if (testMode != `TM_PN_LONG)
        pnLong_q <= `PN_LONG_SEED;
      else if (sampleTick)
        pnLong_q <= pnLongNext[22:0];
      if (sampleTick)
      begin
        lastRaw_q <= raw;
        slot_q[slotIdx] <= word;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // packet assembly and serial output

  always @*
  begin
    body = {headerByte, slot_q[0], slot_q[1], slot_q[2], slot_q[3]};
    case (scrambleCover)
      `COVER_56: inCover = (pos < `DATA_END);
      `COVER_48: inCover = (pos >= `HEADER_BITS) && (pos < `DATA_END);
      default: inCover = 1'b1;
    endcase
    longBit = pkt_q[63];
    shortBit = pkt_q[63];
    if (inCover)
    begin
      longBit = pkt_q[63] ^ scrLong_q[57] ^ scrLong_q[38];
      shortBit = pkt_q[63] ^ scrShort_q[6] ^ scrShort_q[5];
    end
    case (scrambleSel)
      `SCR_LONG: txBit = longBit;
      `SCR_SHORT: txBit = shortBit;
      `SCR_INVERT: txBit = pkt_q[63] ^ INV_MASK[~pos];
      default: txBit = pkt_q[63];
    endcase
  end

  // the scrambler sits after the ecc so the receiver checks clear data
  always @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      pkt_q <= 64'h0000_0000_0000_0000;
      scrLong_q <= {58{1'b0}};
      scrShort_q <= 7'h00;
      serialOut <= 1'b0;
      packetStart <= 1'b0;
    end
    else
    begin
      if (bitCnt_q == 6'h00)
        pkt_q <= {body, 1'b0, eccBits(body)};
      else
        pkt_q <= {pkt_q[62:0], 1'b0};
      scrLong_q <= {scrLong_q[56:0], longBit};
      scrShort_q <= {scrShort_q[5:0], shortBit};
      serialOut <= txBit ^ invertOut;
      packetStart <= (pos == 6'h00);
    end
  end
endmodule

// [verif/adc_serial_packet_encoder_sva.sv]
// assertions on the serial packet encoder ports
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module adc_serial_packet_encoder_sva (
  input wire ref_clk,
  input wire reset_n,
  input wire sampleReady,
  input wire [3:0] testMode,
  input wire invertOut,
  input wire [1:0] scrambleSel,
  input wire regWrEn,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire [7:0] regRdData,
  input wire serialOut,
  input wire packetStart
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // edges spent in toggle mode without a break, saturating
  reg [6:0] toggleAge = 7'h00;
  always @(posedge ref_clk)
    toggleAge <= (testMode != 4'h7) ? 7'h00 :
      toggleAge + {6'h00, toggleAge != 7'h7F};
  start_period_a: assert property (packetStart |-> ##64 packetStart)
    else $error("packet start spacing wrong");
  start_gap_a: assert property (packetStart |=> !packetStart [*8])
    else $error("packet start too early");
  first_packet_a: assert property (
    $rose(reset_n) |-> ##[1:3] packetStart)
    else $error("no packet after reset");
  ready_reset_a: assert property ($rose(reset_n) |=> sampleReady)
    else $error("sample input not ready after reset");
  reg_readback_a: assert property (
    regWrEn && regAddr inside {[8'h19:8'h20]} ##1 !regWrEn &&
    $stable(regAddr) |=> regRdData == $past(regWrData, 2))
    else $error("written byte not read back");
  unmapped_zero_a: assert property (
    !(regAddr inside {[8'h19:8'h20]}) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  // the bit may only differ through inversion or a scrambler
  ecc_top_a: assert property (packetStart |-> ##56 (!serialOut ||
    $past(invertOut) || $past(scrambleSel) != 2'h0))
    else $error("ecc top bit not zero");
  // the reset look-back skips packets that still carry zero slots
  toggle_a: assert property (packetStart && testMode == 4'h7 &&
    toggleAge >= 7'h3C && $past(reset_n, 70) |-> ##8
    (serialOut || $past(invertOut) || $past(scrambleSel) != 2'h0) ##12
    (!serialOut || $past(invertOut) || $past(scrambleSel) != 2'h0))
    else $error("toggle words wrong");
  cover property (packetStart && testMode == 4'h7);
  cover property (!sampleReady);
  cover property (regWrEn);
endmodule

bind adc_serial_packet_encoder adc_serial_packet_encoder_sva chk (
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .sampleReady(sampleReady),
  .testMode(testMode),
  .invertOut(invertOut),
  .scrambleSel(scrambleSel),
  .regWrEn(regWrEn),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regRdData(regRdData),
  .serialOut(serialOut),
  .packetStart(packetStart)
);

// [verif/serial_rx_model.sv]
// receiver model: gathers packets from the start mark and descrambles
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module serial_rx_model (
  input wire ref_clk,
  input wire serialIn,
  input wire frameStart,
  input wire [1:0] scrambleSel,
  input wire [1:0] scrambleCover,
  output logic [63:0] rawPkt,
  output logic [63:0] plainPkt,
  output logic pktDone
);
  logic [57:0] hist = 58'h0;
  logic [63:0] rawSh = 64'h0;
  logic [63:0] plainSh = 64'h0;
  logic key;
  logic covered;
  int idx = 64;
  int i;
  initial pktDone = 1'h0;
  // history holds received bits, so it locks without any shared seed
  always @(posedge ref_clk)
  begin
    i = frameStart ? 0 : idx;
    key = scrambleSel == 2'h1 ? hist[57] ^ hist[38] :
      scrambleSel == 2'h2 ? hist[6] ^ hist[5] : 1'h0;
    covered = scrambleCover == 2'h0 ||
      (i < 56 && (scrambleCover == 2'h1 || i >= 8));
    rawSh = {rawSh[62:0], serialIn};
    plainSh = {plainSh[62:0], serialIn ^ (key & covered)};
    hist <= {hist[56:0], serialIn};
    pktDone <= i == 63;
    if (i == 63)
    begin
      rawPkt <= rawSh;
      plainPkt <= plainSh;
    end
    idx <= i < 64 ? i + 1 : 64;
  end
endmodule

// [verif/adc_serial_packet_encoder_bench.sv]
// bench for the serial packet encoder: registers, patterns, scramblers
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    checksDone++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("wrong value %s expected %0h seen %0h", nm, e, g); \
    end \
  end
////////////////////////////////////////////////////////////////////////////
module adc_serial_packet_encoder_bench;
  localparam [63:0] MASK = 64'h00FF_0F0F_0F0F_0F00;
  localparam [7:0] HDR = 8'h3C;
  logic ref_clk = 1'h0;
  logic reset_n = 1'h0;
  logic [11:0] sampleIn = 12'h000;
  logic sampleValid = 1'h0;
  logic [3:0] testMode = 4'h0;
  logic [3:0] wordLen = 4'hC;
  logic [1:0] dataFormat = 2'h0;
  logic lsbFirst = 1'h0;
  logic invertOut = 1'h0;
  logic [1:0] scrambleSel = 2'h0;
  logic [1:0] scrambleCover = 2'h0;
  logic regWrEn = 1'h0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  wire sampleReady, serialOut, packetStart, pktDone;
  wire [7:0] regRdData;
  wire [63:0] rawPkt, plainPkt;
  int miscompares = 0;
  int checksDone = 0;
  logic [7:0] user [8];
  // {mode, length, format, lsb first, invert, scrambler, cover} then slots
  logic [63:0] tab [11] = '{
    {16'h1C00, {4{12'h800}}}, {16'h2C00, {4{12'hFFF}}},
    {16'h3C00, 48'h0}, {16'h4C00, {2{24'hAAA555}}},
    {16'h7C00, {2{24'hFFF000}}}, {16'h1C40, 48'h0},
    {16'h1C80, {4{12'hC00}}}, {16'h4C40, {2{24'hAAA555}}},
    {16'h7C80, {2{24'hFFF000}}}, {16'h2800, {4{12'hFF0}}},
    {16'h2820, {4{12'h0FF}}}};

  adc_serial_packet_encoder #(.INV_MASK(MASK)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .sampleIn(sampleIn),
    .sampleValid(sampleValid), .sampleReady(sampleReady),
    .headerByte(HDR), .testMode(testMode), .wordLen(wordLen),
    .dataFormat(dataFormat), .lsbFirst(lsbFirst), .invertOut(invertOut),
    .scrambleSel(scrambleSel), .scrambleCover(scrambleCover),
    .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .serialOut(serialOut),
    .packetStart(packetStart));
  serial_rx_model rx (
    .ref_clk(ref_clk), .serialIn(serialOut), .frameStart(packetStart),
    .scrambleSel(scrambleSel), .scrambleCover(scrambleCover),
    .rawPkt(rawPkt), .plainPkt(plainPkt), .pktDone(pktDone));

  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
////////////////////////////////////////////////////////////////////////////
  function automatic [63:0] mkPkt(input [55:0] hd);
    logic [63:0] pos;
    logic [7:0] ecc;
    int j;
    pos = 64'h0;
    ecc = 8'h00;
    j = 55;
    // hamming positions skip the powers of two, parity goes to the tail
    for (int p = 63; p >= 5; p--)
      if (p != 32 && p != 16 && p != 8)
      begin
        pos[p] = hd[j];
        j--;
      end
    for (int k = 0; k < 6; k++)
      for (int p = 5; p < 64; p++)
        ecc[k] = ecc[k] ^ (pos[p] & p[k]);
    ecc[6] = ^{hd, ecc[5:0]};
    return {hd, ecc};
  endfunction

  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input [7:0] a, input [7:0] d);
    @(negedge ref_clk);
    regWrEn = 1'h1;
    regAddr = a;
    regWrData = d;
    @(negedge ref_clk);
    regWrEn = 1'h0;
  endtask

  task automatic rd(input [7:0] a, input [7:0] e);
    @(negedge ref_clk);
    regAddr = a;
    @(negedge ref_clk);
    `CHK("regRdData", e, regRdData)
  endtask

  task automatic nextPkt;
    for (int n = 0; n < 200 && !pktDone; n++)
      @(negedge ref_clk);
    if (pktDone !== 1'h1)
    begin
      miscompares++;
      tallyAndFinish();
    end
    @(negedge ref_clk);
  endtask

  // settings change just after a packet start; the packet in flight is
  // mixed, so it is dropped
  task automatic cfg(input [15:0] c);
    for (int n = 0; n < 100 && !packetStart; n++)
      @(negedge ref_clk);
    if (packetStart !== 1'h1)
    begin
      miscompares++;
      tallyAndFinish();
    end
    {testMode, wordLen, dataFormat, lsbFirst, invertOut, scrambleSel,
      scrambleCover} = c;
    // the older packet ends in this same cycle; let its pulse pass
    @(negedge ref_clk);
    nextPkt();
  endtask

  task automatic chkPkt(input [47:0] d, input [63:0] flip, input plain);
    logic [63:0] pk;
    nextPkt();
    pk = plain ? plainPkt : rawPkt;
    `CHK("packet", mkPkt({HDR, d}) ^ flip, pk)
    // receiver side: recompute parity over what arrived
    if (flip == 64'h0)
      `CHK("parity", mkPkt(pk[63:8]), pk)
  endtask
////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(negedge ref_clk);
    reset_n = 1'h1;
    for (int i = 0; i < 8; i++)
    begin
      user[i] = {4'(i), 4'(15 - i)};
      rd(8'(8'h19 + i), 8'h00);
      wr(8'(8'h19 + i), user[i]);
      rd(8'(8'h19 + i), user[i]);
    end
    wr(8'h21, 8'h77);
    rd(8'h21, 8'h00);
    rd(8'h18, 8'h00);
    cfg(16'h8C00);
    chkPkt({user[0], user[1][7:4], user[2], user[3][7:4], user[4],
      user[5][7:4], user[6], user[7][7:4]}, 64'h0, 1'h0);
    for (int i = 0; i < 11; i++)
    begin
      cfg(tab[i][63:48]);
      chkPkt(tab[i][47:0], 64'h0, 1'h0);
    end
    cfg(16'h6C00);
    nextPkt();
    `CHK("short sequence", 36'hDF9353301, rawPkt[55:20])
    cfg(16'h5C00);
    nextPkt();
    `CHK("long sequence", 36'h591FD70A3, rawPkt[55:20])
    cfg(16'h3C10);
    chkPkt(48'h0, {64{1'h1}}, 1'h0);
    cfg(16'h2C0C);
    chkPkt({4{12'hFFF}}, MASK, 1'h0);
    for (int s = 1; s < 3; s++)
      for (int c = 0; c < 3; c++)
      begin
        cfg({12'h2C0, 2'(s), 2'(c)});
        chkPkt({4{12'hFFF}}, 64'h0, 1'h1);
        `CHK("scrambled", 1'h1, rawPkt != plainPkt)
      end
    cfg(16'h0C40);
    sampleIn = 12'h5A5;
    sampleValid = 1'h1;
    for (int n = 0; n < 40 && sampleReady; n++)
      @(negedge ref_clk);
    `CHK("sampleReady", 1'h0, sampleReady)
    sampleValid = 1'h0;
    repeat (3) nextPkt();
    `CHK("sampleReady", 1'h1, sampleReady)
    chkPkt({4{12'hDA5}}, 64'h0, 1'h0);
    tallyAndFinish();
  end
endmodule
